/* File: core/mag_readout.v */
// Magnetometer read-out register block: mode, results, status, identity, temperature
`timescale 1ns/1ps
`include "mag_readout_regs.vh"
module mag_readout #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Register port from the serial-bus front end
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // Conversion core
    input  wire [15:0] conv_x_i,
    input  wire [15:0] conv_y_i,
    input  wire [15:0] conv_z_i,
    input  wire [11:0] conv_temp_i,
    output wire        conv_start_o,
    output wire        conv_active_o,
    output wire [2:0]  rate_o,
    output wire        new_data_o
);

    // ****************************************
    // Decode helpers and sequencer states
    // ****************************************
    localparam [1:0] CONV_SLEEP  = 2'b00;
    localparam [1:0] CONV_CONT   = 2'b01;
    localparam [1:0] CONV_SINGLE = 2'b10;
    localparam [1:0] CONV_DONE   = 2'b11;

    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Both sleep codes collapse to one state
    function [1:0] mode_state;
        input [1:0] mode;
        begin
            case (mode)
                `MODE_CONTINUOUS: mode_state = CONV_CONT;
                `MODE_SINGLE:     mode_state = CONV_SINGLE;
                default:          mode_state = CONV_SLEEP;
            endcase
        end
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    reg  [2:0]  rate_reg;
    reg  [2:0]  rate_next;
    reg  [1:0]  mode_reg;
    reg  [1:0]  mode_next;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;

    wire        mode_wr = reg_wr_i && addr_hit(reg_addr_i, `ADDR_MODE_REG);
    // Sleep and a finished single conversion both stop the ticker
    wire        run     = (state_reg == CONV_CONT) || (state_reg == CONV_SINGLE);

    always @* begin
        rate_next = rate_reg;
        mode_next = mode_reg;
        if (reg_wr_i) begin
            // Only the two writable addresses decode; all others drop the write
            case (reg_addr_i)
                `ADDR_RATE_CTRL: rate_next = reg_wdata_i[`RATE_MSB:`RATE_LSB];
                `ADDR_MODE_REG:  mode_next = reg_wdata_i[1:0];
                default: ;
            endcase
        end
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rate_reg <= `RATE_RESET;
            mode_reg <= `MODE_RESET;
        end else begin
            rate_reg <= rate_next;
            mode_reg <= mode_next;
        end
    end

    // ****************************************
    // Conversion pacing
    // ****************************************
    wire tick;

    rate_ticker #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_ticker (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .run_i     (run),
        .restart_i (mode_wr),
        .rate_i    (rate_reg),
        .tick_o    (tick)
    );

    // Single conversion ends on its first tick, which captures unless locked, then idles until rewritten
    always @* begin
        state_next = state_reg;
        if (mode_wr) begin
            state_next = mode_state(reg_wdata_i[1:0]);
        end else begin
            case (state_reg)
                CONV_SINGLE: begin
                    if (tick)
                        state_next = CONV_DONE;
                end
                CONV_CONT:   state_next = CONV_CONT;
                CONV_DONE:   state_next = CONV_DONE;
                default:     state_next = CONV_SLEEP;
            endcase
        end
    end

    // A mode write also restarts the period in the ticker
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            state_reg <= CONV_SLEEP;
        else
            state_reg <= state_next;
    end

    // ****************************************
    // Result capture and status
    // ****************************************
    reg [15:0] x_reg;
    reg [15:0] y_reg;
    reg [15:0] z_reg;
    reg [11:0] temp_reg;
    reg        ready_reg;
    reg        ready_next;
    reg        lock_reg;
    reg        lock_next;

    wire rd_first = reg_rd_i && addr_hit(reg_addr_i, `ADDR_FIELD_X_HIGH);
    wire rd_last  = reg_rd_i && addr_hit(reg_addr_i, `ADDR_FIELD_Y_LOW);

    // Capture held off while locked so a multi-byte read stays coherent
    wire capture = tick && !lock_reg;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            x_reg    <= 16'h0000;
            y_reg    <= 16'h0000;
            z_reg    <= 16'h0000;
            temp_reg <= 12'h000;
        end else if (capture) begin
            x_reg    <= conv_x_i;
            z_reg    <= conv_z_i;
            y_reg    <= conv_y_i;
            temp_reg <= conv_temp_i;
        end
    end

    // Set wins over clear on the same edge
    always @* begin
        ready_next = ready_reg;
        lock_next  = lock_reg;
        if (capture)
            ready_next = 1'b1;
        else if (rd_last)
            ready_next = 1'b0;
        if (rd_first && ready_reg)
            lock_next = 1'b1;
        else if (rd_last)
            lock_next = 1'b0;
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_reg <= 1'b0;
            lock_reg  <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            lock_reg  <= lock_next;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    reg [7:0] rdata_next;

    // Read data holds between reads so a slow front end can fetch it late
    always @* begin
        rdata_next = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_RATE_CTRL:    rdata_next = {3'h0, rate_reg, 2'h0};
                `ADDR_MODE_REG:     rdata_next = {6'h00, mode_reg};
                `ADDR_FIELD_X_HIGH: rdata_next = x_reg[15:8];
                `ADDR_FIELD_X_LOW:  rdata_next = x_reg[7:0];
                `ADDR_FIELD_Z_HIGH: rdata_next = z_reg[15:8];
                `ADDR_FIELD_Z_LOW:  rdata_next = z_reg[7:0];
                `ADDR_FIELD_Y_HIGH: rdata_next = y_reg[15:8];
                `ADDR_FIELD_Y_LOW:  rdata_next = y_reg[7:0];
                `ADDR_FIELD_STATUS: rdata_next = {6'h00, lock_reg, ready_reg};
                `ADDR_IDENT_FIRST:  rdata_next = `IDENT_FIRST_VAL;
                `ADDR_IDENT_SECOND: rdata_next = `IDENT_SECOND_VAL;
                `ADDR_IDENT_THIRD:  rdata_next = `IDENT_THIRD_VAL;
                `ADDR_TEMP_HIGH:    rdata_next = temp_reg[11:4];
                `ADDR_TEMP_LOW:     rdata_next = {temp_reg[3:0], 4'h0};
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rdata_next;
    end

    assign conv_start_o  = capture;
    assign conv_active_o = run;
    assign rate_o        = rate_reg;
    assign new_data_o    = ready_reg;

endmodule // mag_readout

/* File: core/mag_readout_regs.vh */
// Register offsets, fields, reset values and timing for the magnetometer read-out block
`ifndef MAG_READOUT_REGS_VH
`define MAG_READOUT_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_RATE_CTRL    8'h00
`define ADDR_MODE_REG     8'h02
`define ADDR_FIELD_X_HIGH 8'h03
`define ADDR_FIELD_X_LOW  8'h04
`define ADDR_FIELD_Z_HIGH 8'h05
`define ADDR_FIELD_Z_LOW  8'h06
`define ADDR_FIELD_Y_HIGH 8'h07
`define ADDR_FIELD_Y_LOW  8'h08
`define ADDR_FIELD_STATUS 8'h09
`define ADDR_IDENT_FIRST  8'h0a
`define ADDR_IDENT_SECOND 8'h0b
`define ADDR_IDENT_THIRD  8'h0c
`define ADDR_TEMP_HIGH    8'h31
`define ADDR_TEMP_LOW     8'h32

// ****************************************
// Fields and reset values
// ****************************************
`define RATE_LSB          2
`define RATE_MSB          4
`define RATE_RESET        3'h4
`define MODE_RESET        2'h3
`define MODE_CONTINUOUS   2'h0
`define MODE_SINGLE       2'h1
`define STATUS_LOCK_BIT   1
`define STATUS_READY_BIT  0

// ****************************************
// Identification bytes (values arbitrary)
// ****************************************
`define IDENT_FIRST_VAL   8'h5a
`define IDENT_SECOND_VAL  8'h3c
`define IDENT_THIRD_VAL   8'h66

// ****************************************
// Timing: 250 MHz clock, 4 ns period
// ****************************************
`define CLOCK_PERIOD_NS   4
`define TICK_US           1
`define TICK_CYCLES       (`TICK_US * 1000 / `CLOCK_PERIOD_NS)

`endif

/* File: core/rate_ticker.v */
// Conversion-rate divider: one-cycle pulse per conversion period
`timescale 1ns/1ps
`include "mag_readout_regs.vh"
module rate_ticker #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Control
    input  wire        run_i,
    input  wire        restart_i,
    input  wire [2:0]  rate_i,
    // Pulse out
    output wire        tick_o
);

    // ****************************************
    // Period in microsecond ticks per rate code
    // ****************************************
    function [31:0] period_us;
        input [2:0] code;
        begin
            case (code)
                3'h0: period_us = 32'd1333333;
                3'h1: period_us = 32'd666667;
                3'h2: period_us = 32'd333333;
                3'h3: period_us = 32'd133333;
                3'h4: period_us = 32'd66667;
                3'h5: period_us = 32'd33333;
                3'h6: period_us = 32'd13333;
                default: period_us = 32'd4545;
            endcase
        end
    endfunction

    reg [15:0] pre_reg;
    reg [31:0] us_reg;
    wire       us_tick = (pre_reg == TICK_CYCLES - 1);

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= 16'h0000;
            us_reg  <= 32'h00000000;
        end else if (!run_i || restart_i) begin
            pre_reg <= 16'h0000;
            us_reg  <= 32'h00000000;
        end else if (us_tick) begin
            pre_reg <= 16'h0000;
            // Counter restarts at zero on >= so a change to a faster code never wraps
            if (us_reg >= period_us(rate_i) - 32'd1)
                us_reg <= 32'h00000000;
            else
                us_reg <= us_reg + 32'd1;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end

    assign tick_o = run_i && !restart_i && us_tick && (us_reg >= period_us(rate_i) - 32'd1);

endmodule // rate_ticker

/* File: tb/host_model.sv */
// Host model issuing register cycles
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       clock_i,
    // Register cycle out
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic      [7:0] wdata_o,
    output logic            rd_o
);
    initial {addr_o, wr_o, wdata_o, rd_o} = 18'h0;
    // Idle bus shows the inverse, so stale values never pass
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
        @(posedge clock_i);
        #1;
        {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
    endtask
endmodule // host_model

/* File: tb/mag_readout_checker.sv */
// Port assertions for the magnetometer read-out block
`timescale 1ns/1ps
`include "mag_readout_regs.vh"
module mag_readout_checker (
    // Clock, reset, register port
    input wire logic       clock_i,
    input wire logic       nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Core side
    input wire logic       conv_start_o,
    input wire logic       conv_active_o,
    input wire logic [2:0] rate_o,
    input wire logic       new_data_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire       wm = reg_wr_i && reg_addr_i == `ADDR_MODE_REG;
    wire [2:0] wr_rate = reg_wdata_i[4:2];
    property p_ident; reg_rd_i && reg_addr_i == `ADDR_IDENT_FIRST |=> reg_rdata_o == `IDENT_FIRST_VAL; endproperty
    a_ident: assert property (p_ident) else $error("ident byte");
    property p_ready; conv_start_o |=> new_data_o; endproperty
    a_ready: assert property (p_ready) else $error("new data flag");
    property p_sleep; wm && reg_wdata_i[1] |=> !conv_active_o; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep mode");
    property p_cont; wm && reg_wdata_i[1:0] == 2'h0 |=> conv_active_o; endproperty
    a_cont: assert property (p_cont) else $error("continuous mode");
    property p_rst; $rose(nrst_i) |-> rate_o == `RATE_RESET; endproperty
    a_rst: assert property (p_rst) else $error("rate reset");
    property p_rate; reg_wr_i && reg_addr_i == `ADDR_RATE_CTRL |=> rate_o == $past(wr_rate); endproperty
    a_rate: assert property (p_rate) else $error("rate write");
    property p_stat; reg_rd_i && reg_addr_i == `ADDR_FIELD_STATUS && new_data_o |=> reg_rdata_o[0]; endproperty
    a_stat: assert property (p_stat) else $error("status ready bit");
    // Sleep must never capture, or stale sets would look fresh
    property p_quiet; !conv_active_o |-> !conv_start_o; endproperty
    a_quiet: assert property (p_quiet) else $error("capture while idle");
    property p_lock; reg_rd_i && reg_addr_i == `ADDR_FIELD_X_HIGH && new_data_o |=> !conv_start_o; endproperty
    a_lock: assert property (p_lock) else $error("capture while locked");
    property p_pad; reg_rd_i && reg_addr_i == `ADDR_MODE_REG |=> reg_rdata_o[7:2] == 6'h00; endproperty
    a_pad: assert property (p_pad) else $error("mode register upper bits");
    c_cap: cover property (conv_start_o);
    c_lock: cover property (reg_rd_i && reg_addr_i == `ADDR_FIELD_X_HIGH && new_data_o);
    c_mode: cover property (wm);
endmodule // mag_readout_checker
bind mag_readout mag_readout_checker chk (.clock_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .conv_start_o, .conv_active_o, .rate_o, .new_data_o);

/* File: tb/magnetometer_readout_regs_bench.sv */
// Self-checking bench for the magnetometer read-out block
`timescale 1ns/1ps
`include "mag_readout_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module magnetometer_readout_regs_bench;
    logic        clock_i = 1'b0, nrst_i = 1'b0, wr, rd, conv_start, conv_active, new_data, rd_seen = 1'b0;
    logic [7:0]  addr, wdata, rdata, e;
    logic [15:0] cx = 16'h0, cy = 16'h0, cz = 16'h0, kx, ky, kz;
    logic [11:0] ct = 12'h0, kt;
    logic [2:0]  rate;
    logic [31:0] seed = 32'h7d6df5ba, t, u;
    logic [7:0]  exp_q[$];
    int          n_fail = 0, total_checks = 0, i;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    initial forever #2 clock_i = ~clock_i;
    mag_readout #(.TICK_CYCLES(1)) DUT (.clock_i, .nrst_i, .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .conv_x_i(cx), .conv_y_i(cy), .conv_z_i(cz), .conv_temp_i(ct),
        .conv_start_o(conv_start), .conv_active_o(conv_active), .rate_o(rate), .new_data_o(new_data));
    host_model host (.clock_i, .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    always @(posedge clock_i) begin
        #1;
        {cx, cy} = xs();
        u = xs();
        {cz, ct} = u[27:0];
    end
    // Answer lands one edge after the read is taken
    always @(posedge clock_i) begin
        if (conv_start) {kx, ky, kz, kt} <= {cx, cy, cz, ct};
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("rdata", e, rdata)
        end
        rd_seen <= rd;
    end
    task automatic rdx(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.cyc(1'b0, a, 8'h00);
    endtask
    task automatic wait_ready();
        for (i = 0; i < 6000 && new_data !== 1'b1; i++) begin
            @(posedge clock_i);
            #1;
        end
        if (i >= 6000) n_fail++;
    endtask
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(4 * 40000);
        n_fail++;
        results();
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (12) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        rdx(8'h00, 8'h10);
        rdx(8'h02, 8'h03);
        rdx(8'h0a, `IDENT_FIRST_VAL);
        rdx(8'h0b, `IDENT_SECOND_VAL);
        rdx(8'h0c, `IDENT_THIRD_VAL);
        rdx(8'h20, 8'h00);
        for (i = 0; i < 8; i++) begin
            host.cyc(1'b1, 8'h00, {3'h0, i[2:0], 2'h0});
            rdx(8'h00, {3'h0, i[2:0], 2'h0});
        end
        for (i = 0; i < 5; i++) begin
            host.cyc(1'b1, 8'h02, i == 4 ? 8'hff : i[7:0]);
            rdx(8'h02, i == 4 ? 8'h03 : i[7:0]);
            `CHK("active", i < 2, conv_active)
        end
        host.cyc(1'b1, 8'h02, 8'h00);
        wait_ready();
        rdx(8'h09, 8'h01);
        rdx(8'h03, kx[15:8]);
        for (i = 3; i < 13; i++) begin
            t = xs();
            host.cyc(1'b1, i[7:0], t[7:0]);
        end
        host.cyc(1'b1, 8'h31, t[15:8]);
        rdx(8'h09, 8'h03);
        rdx(8'h0c, `IDENT_THIRD_VAL);
        rdx(8'h04, kx[7:0]);
        rdx(8'h05, kz[15:8]);
        rdx(8'h06, kz[7:0]);
        rdx(8'h07, ky[15:8]);
        rdx(8'h31, kt[11:4]);
        rdx(8'h32, {kt[3:0], 4'h0});
        rdx(8'h08, ky[7:0]);
        rdx(8'h09, 8'h00);
        host.cyc(1'b1, 8'h02, 8'h01);
        wait_ready();
        repeat (2) @(posedge clock_i);
        `CHK("single", 1'b0, conv_active)
        results();
    end
endmodule // magnetometer_readout_regs_bench
